// [pbhms_params.svh]
// timing, band limits and press-count constants for the push-button hold selector
// assumes a single core clock; second-based times are converted in the top module
`ifndef PBHMS_PARAMS_SVH
`define PBHMS_PARAMS_SVH

`define PBHMS_CLK_HZ      40000000
`define PBHMS_MS_PER_S    1000
`define PBHMS_TICK_S      1
`define PBHMS_DB_MS       20

`define PBHMS_BAND_RST    6
`define PBHMS_BAND_CAL    12
`define PBHMS_BAND_WIN    18
`define PBHMS_BAND_END    24
`define PBHMS_SEC_MAX     31

`define PBHMS_WIN_S       14
`define PBHMS_VALID_S     2
`define PBHMS_FLASH_S     2

`define PBHMS_CNT_TOT1    1
`define PBHMS_CNT_TOT2    2
`define PBHMS_CNT_BOTH    3
`define PBHMS_CNT_PORT    4

`endif

// [pbhms_pkg.sv]
// types shared by the push-button hold selector modules
// assumes nothing beyond a SystemVerilog compiler
package pbhms_pkg;

    typedef enum logic [1:0] {
        PORT_OFF   = 2'h0,
        PORT_SER_A = 2'h1,
        PORT_SER_B = 2'h2
    } pbhms_port_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_HOLD   = 3'h1,
        ST_REPORT = 3'h2,
        ST_WIN    = 3'h3,
        ST_WPRESS = 3'h4
    } pbhms_state_t;

    typedef struct packed {
        logic green;
        logic red;
        logic amber;
    } pbhms_led_t;

    typedef struct packed {
        logic inst_reset;
        logic clr_alerts;
        logic self_test;
        logic zero_cal;
        logic tot1_reset;
        logic tot2_reset;
    } pbhms_act_t;

    function automatic pbhms_port_t pbhms_port_adv(input pbhms_port_t m);
        case (m)
            PORT_OFF:   return PORT_SER_A;
            PORT_SER_A: return PORT_SER_B;
            default:    return PORT_OFF;
        endcase
    endfunction

endpackage

// [pbhms_debounce.sv]
// debouncer for one mechanical contact, with registered edge pulses
// assumes raw is already synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module pbhms_debounce #(
    parameter int DB_CYC = 800000
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic raw,
    output var  logic level,
    output var  logic rise,
    output var  logic fall
);
    localparam int CW = $clog2(DB_CYC + 1);

    logic [CW-1:0] cnt_reg, cnt_next;
    logic          lvl_reg, lvl_next;
    logic          rise_reg, rise_next;
    logic          fall_reg, fall_next;

    // the new level must stand unbroken for DB_CYC cycles before it is taken
    always_comb begin
        cnt_next  = cnt_reg;
        lvl_next  = lvl_reg;
        rise_next = 1'b0;
        fall_next = 1'b0;
        if (raw == lvl_reg) begin
            cnt_next = '0;
        end else if (cnt_reg == CW'(DB_CYC - 1)) begin
            cnt_next  = '0;
            lvl_next  = raw;
            rise_next = raw;
            fall_next = ~raw;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg  <= '0;
            lvl_reg  <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            lvl_reg  <= lvl_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign level = lvl_reg;
    assign rise  = rise_reg;
    assign fall  = fall_reg;
endmodule

`default_nettype wire

// [pbhms_top.sv]
// push-button hold selector: times a held button, shows the band on the LEDs,
// and issues one-cycle action pulses on release or at the end of the entry window
// assumes BTN_N is synchronous to CORE_CLK and the action pulses are caught by
// logic running on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pbhms_params.svh"

// Function
// - A release after less than six seconds only reports the port mode on the LED.
// - The port mode is shown as one, two or three amber flashes for off, first and second serial.
// - From six to twelve seconds amber flashes, and a release there resets the instrument.
// - The button reset restarts the program, clears warnings and errors and requests a self-test.
// - From twelve to eighteen seconds green flashes, and a release there starts zero calibration.
// - The button works the same in analogue and digital operation.
// - From eighteen to twenty-four seconds red stays on, and a release opens a fourteen-second window.
// - At window end one press resets totalizer one, two the second, three both, four toggles the port.
// - Each port toggle steps off, first serial, second serial, then back to off.
// - A counted press must be held two seconds, and a short press or none returns to idle with green on.
module pbhms_top
    import pbhms_pkg::*;
#(
    parameter int TICK_CYC = `PBHMS_CLK_HZ * `PBHMS_TICK_S,
    parameter int DB_CYC   = (`PBHMS_CLK_HZ / `PBHMS_MS_PER_S) * `PBHMS_DB_MS
) (
    input  wire logic  CORE_CLK,
    input  wire logic  ARST_N,
    input  wire logic  BTN_N,
    output var  pbhms_led_t  LED,
    output var  pbhms_act_t  ACT,
    output var  pbhms_port_t PORT_MODE
);
    localparam int SW = $clog2(TICK_CYC + 1);

    pbhms_state_t  state_reg, state_next;
    logic [SW-1:0] sub_reg,   sub_next;
    logic [4:0]    sec_reg,   sec_next;
    logic [3:0]    win_reg,   win_next;
    logic [2:0]    cnt_reg,   cnt_next;
    pbhms_port_t   port_reg,  port_next;
    pbhms_led_t    led_reg,   led_next;
    pbhms_act_t    act_reg,   act_next;
    logic          restart;
    logic          tick;
    logic          btn_raw;
    logic          press;
    logic          rel;
    logic [4:0]    rep_end;

    assign btn_raw = ~BTN_N;

    pbhms_debounce #(
        .DB_CYC (DB_CYC)
    ) u_debounce (
        .clk    (CORE_CLK),
        .arst_n (ARST_N),
        .raw    (btn_raw),
        .level  (),
        .rise   (press),
        .fall   (rel)
    );

    // the sub-second counter restarts on every edge so hold time is exact to a cycle
    assign tick    = (sub_reg == SW'(TICK_CYC - 1));
    assign rep_end = 5'(`PBHMS_FLASH_S) * (5'(port_reg) + 5'h01);

    always_comb begin
        state_next = state_reg;
        sec_next   = sec_reg;
        win_next   = win_reg;
        cnt_next   = cnt_reg;
        port_next  = port_reg;
        act_next   = '0;
        restart    = 1'b0;
        if (tick && sec_reg != 5'(`PBHMS_SEC_MAX)) begin
            sec_next = sec_reg + 5'h01;
        end
        if (tick && win_reg != 4'(`PBHMS_WIN_S)) begin
            win_next = win_reg + 4'h1;
        end
        case (state_reg)
            ST_IDLE: begin
                // no operating-mode input gates the button path
                if (press) begin
                    state_next = ST_HOLD;
                    sec_next   = '0;
                    restart    = 1'b1;
                end
            end
            ST_HOLD: begin
                if (rel) begin
                    restart  = 1'b1;
                    sec_next = '0;
                    if (sec_reg < 5'(`PBHMS_BAND_RST)) begin
                        state_next = ST_REPORT;
                    end else if (sec_reg < 5'(`PBHMS_BAND_CAL)) begin
                        act_next.inst_reset = 1'b1;
                        act_next.clr_alerts = 1'b1;
                        act_next.self_test  = 1'b1;
                        state_next          = ST_IDLE;
                    end else if (sec_reg < 5'(`PBHMS_BAND_WIN)) begin
                        act_next.zero_cal = 1'b1;
                        state_next        = ST_IDLE;
                    end else if (sec_reg < 5'(`PBHMS_BAND_END)) begin
                        state_next = ST_WIN;
                        win_next   = '0;
                        cnt_next   = '0;
                    end else begin
                        // beyond the last band the hold is treated as abandoned
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_REPORT: begin
                if (press) begin
                    state_next = ST_HOLD;
                    sec_next   = '0;
                    restart    = 1'b1;
                end else if (sec_reg == rep_end) begin
                    state_next = ST_IDLE;
                end
            end
            ST_WIN: begin
                if (press) begin
                    state_next = ST_WPRESS;
                    sec_next   = '0;
                    restart    = 1'b1;
                end else if (win_reg == 4'(`PBHMS_WIN_S)) begin
                    state_next = ST_IDLE;
                    case (cnt_reg)
                        3'(`PBHMS_CNT_TOT1): act_next.tot1_reset = 1'b1;
                        3'(`PBHMS_CNT_TOT2): act_next.tot2_reset = 1'b1;
                        3'(`PBHMS_CNT_BOTH): begin
                            act_next.tot1_reset = 1'b1;
                            act_next.tot2_reset = 1'b1;
                        end
                        3'(`PBHMS_CNT_PORT): port_next = pbhms_port_adv(port_reg);
                        default: ;
                    endcase
                end
            end
            ST_WPRESS: begin
                if (rel) begin
                    restart  = 1'b1;
                    sec_next = '0;
                    if (sec_reg >= 5'(`PBHMS_VALID_S)) begin
                        state_next = ST_WIN;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end else if (tick && sec_reg == 5'(`PBHMS_VALID_S - 1) && cnt_reg != '1) begin
                    cnt_next = cnt_reg + 3'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        sub_next = (restart || tick) ? '0 : sub_reg + 1'b1;
    end

    // LEDs follow the next state so they change on the same edge as the state
    always_comb begin
        led_next = '0;
        case (state_next)
            ST_IDLE: led_next.green = 1'b1;
            ST_HOLD: begin
                if (sec_next < 5'(`PBHMS_BAND_CAL)) begin
                    led_next.amber = ~sec_next[0];
                end else if (sec_next < 5'(`PBHMS_BAND_WIN)) begin
                    led_next.green = ~sec_next[0];
                end else if (sec_next < 5'(`PBHMS_BAND_END)) begin
                    led_next.red = 1'b1;
                end
            end
            // the last second must stay dark, else a one-cycle blip reads as an extra flash
            ST_REPORT: led_next.amber = ~sec_next[0] && (sec_next < rep_end);
            ST_WIN:    led_next.red   = 1'b1;
            ST_WPRESS: led_next.green = (sec_next < 5'(`PBHMS_VALID_S));
            default:   led_next = '0;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= ST_IDLE;
            sub_reg   <= '0;
            sec_reg   <= '0;
            win_reg   <= '0;
            cnt_reg   <= '0;
            port_reg  <= PORT_OFF;
            led_reg   <= '0;
            act_reg   <= '0;
        end else begin
            state_reg <= state_next;
            sub_reg   <= sub_next;
            sec_reg   <= sec_next;
            win_reg   <= win_next;
            cnt_reg   <= cnt_next;
            port_reg  <= port_next;
            led_reg   <= led_next;
            act_reg   <= act_next;
        end
    end

    assign LED       = led_reg;
    assign ACT       = act_reg;
    assign PORT_MODE = port_reg;

    // helper: amber flashes seen during the current report
    logic       amber_d;
    logic [2:0] flash_seen;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            amber_d    <= 1'b0;
            flash_seen <= '0;
        end else begin
            amber_d <= (state_reg == ST_REPORT) && LED.amber;
            if (state_reg != ST_REPORT) begin
                flash_seen <= '0;
            end else if (LED.amber && !amber_d) begin
                flash_seen <= flash_seen + 3'h1;
            end
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    chk_short_report: assert property (
        (state_reg == ST_HOLD && rel && sec_reg < 5'(`PBHMS_BAND_RST))
        |=> (state_reg == ST_REPORT && ACT == '0))
        else $error("short hold did not go to report");

    chk_flash_count: assert property (
        (state_reg == ST_REPORT && state_next == ST_IDLE)
        |-> (flash_seen == 3'(port_reg) + 3'h1))
        else $error("wrong number of amber flashes");

    chk_reset_band: assert property (
        (state_reg == ST_HOLD && rel && sec_reg >= 5'(`PBHMS_BAND_RST)
         && sec_reg < 5'(`PBHMS_BAND_CAL))
        |=> ACT.inst_reset ##1 !ACT.inst_reset)
        else $error("reset band release gave no single reset pulse");

    chk_reset_bundle: assert property (
        ACT.inst_reset |-> (ACT.clr_alerts && ACT.self_test && !ACT.zero_cal))
        else $error("reset pulse without clear and self-test");

    chk_zero_band: assert property (
        (state_reg == ST_HOLD && rel && sec_reg >= 5'(`PBHMS_BAND_CAL)
         && sec_reg < 5'(`PBHMS_BAND_WIN))
        |=> (ACT.zero_cal && !ACT.inst_reset && state_reg == ST_IDLE))
        else $error("calibration band release gave no zero pulse");

    chk_hold_release: assert property (
        (state_reg == ST_HOLD && rel) |=> (state_reg != ST_HOLD))
        else $error("release did not end the hold");

    chk_window_red: assert property (
        (state_reg == ST_WIN) |-> (LED.red && !LED.green && !LED.amber))
        else $error("red not steady in entry window");

    chk_port_toggle: assert property (
        (state_reg == ST_WIN && !press && win_reg == 4'(`PBHMS_WIN_S)
         && cnt_reg == 3'(`PBHMS_CNT_PORT))
        |=> (PORT_MODE == pbhms_port_adv($past(PORT_MODE)) && ACT == '0))
        else $error("four presses did not toggle the port");

    chk_port_cycle: assert property (
        (PORT_MODE != $past(PORT_MODE))
        |-> (PORT_MODE == pbhms_port_adv($past(PORT_MODE))))
        else $error("port mode left its cycle");

    chk_short_press: assert property (
        (state_reg == ST_WPRESS && rel && sec_reg < 5'(`PBHMS_VALID_S))
        |=> (state_reg == ST_IDLE && ACT == '0 && LED.green))
        else $error("short counted press not abandoned");
endmodule

`default_nettype wire

// [pbhms_operator.sv]
// stand-in for the person pressing the front-panel button
// assumes the bench calls down and up through this instance, clocked by the core clock
`timescale 1ns/1ps
`default_nettype none

module pbhms_operator (
    input  wire logic clk,
    output var  logic btn_n
);
    initial begin
        btn_n = 1'b1;
    end

    // a real contact chatters for a cycle before it settles, so the debouncer is exercised
    task automatic down();
        @(negedge clk) btn_n = 1'b0;
        @(negedge clk) btn_n = 1'b1;
        @(negedge clk) btn_n = 1'b0;
    endtask

    // the release chatters for a cycle too; the caller sets how long the button stays down
    task automatic up();
        @(negedge clk) btn_n = 1'b1;
        @(negedge clk) btn_n = 1'b0;
        @(negedge clk) btn_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// [tb.sv]
// self-checking bench for the push-button hold selector
// assumes pbhms_operator plays the person; short tick and debounce keep the run small
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pbhms_pkg::*;
    localparam int TICK  = 20;
    localparam int DB    = 3;
    localparam int LIMIT = 15000;

    logic        CORE_CLK = 1'b0;
    logic        ARST_N   = 1'b0;
    wire logic   btn_n;
    pbhms_led_t  led;
    pbhms_act_t  act;
    pbhms_port_t port;
    logic [5:0]  act_acc  = 6'h00;
    logic        amber_q  = 1'b0;
    int          rises    = 0;
    int          cyc      = 0;
    int          n_errors = 0;
    int          n_tests  = 0;

    always #12.5 CORE_CLK = ~CORE_CLK;

    pbhms_top #(.TICK_CYC(TICK), .DB_CYC(DB)) pbhms_top_inst (
        .CORE_CLK  (CORE_CLK),
        .ARST_N    (ARST_N),
        .BTN_N     (btn_n),
        .LED       (led),
        .ACT       (act),
        .PORT_MODE (port)
    );

    pbhms_operator pbhms_operator_inst (
        .clk   (CORE_CLK),
        .btn_n (btn_n)
    );

    // pulses are one cycle wide, so they are gathered here rather than polled
    always @(negedge CORE_CLK) begin
        if (act !== 6'h00) act_acc = act_acc | act;
        if (led.amber === 1'b1 && amber_q !== 1'b1) rises++;
        amber_q = led.amber;
    end

    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask

    task automatic wait_green(input int max);
        int i;
        for (i = 0; i < max && led.green !== 1'b1; i++) @(negedge CORE_CLK);
    endtask

    task automatic test_report(input int flashes);
        pbhms_operator_inst.down();
        cycles(TICK + TICK / 2);
        pbhms_operator_inst.up();
        rises = 0;
        act_acc = 6'h00;
        cycles(DB + 4);
        wait_green(8 * TICK);
        check("report flashes", rises[7:0], flashes[7:0]);
        check("report action", act_acc, 6'h00);
        $display("test report %0d done", flashes);
    endtask

    task automatic test_band(input int sec, input logic [5:0] exp, input pbhms_led_t mask);
        int i;
        pbhms_operator_inst.down();
        cycles((sec - 2) * TICK + TICK / 2);
        check("band led on", led & mask, mask);
        cycles(TICK);
        check("band led off", led & mask, 3'h0);
        cycles(TICK);
        act_acc = 6'h00;
        pbhms_operator_inst.up();
        for (i = 0; i < 2 * DB + 8 && act === 6'h00; i++) @(negedge CORE_CLK);
        check("band action", act, exp);
        cycles(1);
        check("action pulse width", act, 6'h00);
        cycles(3 * TICK);
        check("band actions total", act_acc, exp);
        check("idle led", led, 3'h4);
        $display("test band %0d s done", sec);
    endtask

    task automatic test_window(input int n, input int hold_c, input logic [5:0] exp_act,
                               input pbhms_port_t exp_port);
        int k;
        pbhms_operator_inst.down();
        cycles(20 * TICK + TICK / 2);
        check("band red", led, 3'h2);
        pbhms_operator_inst.up();
        act_acc = 6'h00;
        cycles(DB + 4);
        check("window red", led, 3'h2);
        for (k = 0; k < n; k++) begin
            pbhms_operator_inst.down();
            cycles(DB + 4);
            check("press green", led.green, 1'b1);
            cycles(hold_c - DB - 4);
            if (hold_c > 2 * TICK) check("press counted", led.green, 1'b0);
            pbhms_operator_inst.up();
            cycles(DB + 4);
            if (hold_c > 2 * TICK) check("ready red", led, 3'h2);
        end
        wait_green(16 * TICK);
        cycles(TICK);
        check("window end led", led, 3'h4);
        check("window action", act_acc, exp_act);
        check("port mode", port, exp_port);
        $display("test window %0d presses done", n);
    endtask

    // the block has no operating-mode input, so one mode covers all use
    initial begin
        int i;
        pbhms_port_t seq [3];
        seq = '{PORT_SER_A, PORT_SER_B, PORT_OFF};
        cycles(1);
        check("reset led", led, 3'h0);
        check("reset act", act, 6'h00);
        check("reset port", port, PORT_OFF);
        cycles(3);
        ARST_N = 1'b1;
        cycles(2);
        check("idle led", led, 3'h4);
        for (i = 0; i < 3; i++) begin
            test_report(i + 1);
            test_window(4, 50, 6'h00, seq[i]);
        end
        test_band(8, 6'h38, 3'h1);
        test_band(14, 6'h04, 3'h4);
        test_band(26, 6'h00, 3'h0);
        test_window(1, 50, 6'h02, PORT_OFF);
        test_window(2, 50, 6'h01, PORT_OFF);
        test_window(3, 50, 6'h03, PORT_OFF);
        test_window(1, 10, 6'h00, PORT_OFF);
        tally_and_finish();
    end
endmodule

`default_nettype wire
